// ---- hdl/hhs_pkg.sv ----
// Package with the homing sequencer's modes, segment table entries and reset values.
package hhs_pkg;

  typedef logic [5:0] hhs_mode_t;

  localparam hhs_mode_t HHS_MODE_21 = 6'h15;
  localparam hhs_mode_t HHS_MODE_22 = 6'h16;
  localparam hhs_mode_t HHS_MODE_23 = 6'h17;
  localparam hhs_mode_t HHS_MODE_24 = 6'h18;
  localparam hhs_mode_t HHS_MODE_25 = 6'h19;
  localparam hhs_mode_t HHS_MODE_26 = 6'h1a;

  localparam int HHS_POS_W = 32;
  localparam int HHS_IDX_W = 3;
  localparam int HHS_PIN_N = 3;
  localparam int HHS_PIN_HOME = 0;
  localparam int HHS_PIN_PLIM = 1;
  localparam int HHS_PIN_NLIM = 2;
  localparam logic [HHS_IDX_W-1:0] HHS_IDX_FIRST = 3'h0;
  localparam logic [HHS_IDX_W-1:0] HHS_IDX_AFTER_TURN = 3'h1;
  localparam logic [HHS_IDX_W-1:0] HHS_IDX_STEP = 3'h1;

  // Reset values of the command outputs and of the done, alarm and home position status outputs.
  localparam logic HHS_RST_RUN = 1'b0;
  localparam logic HHS_RST_FWD = 1'b0;
  localparam logic HHS_RST_FAST = 1'b0;
  localparam logic HHS_RST_DECEL = 1'b0;
  localparam logic HHS_RST_ALARM = 1'b0;
  localparam logic HHS_RST_DONE = 1'b0;
  localparam logic [HHS_POS_W-1:0] HHS_RST_POS = 32'h0000_0000;

  // Where the axis stands against the home switch when a search starts.
  typedef enum logic [1:0] {HHS_CS_ON, HHS_CS_OFF_FWD, HHS_CS_OFF_REV} hhs_case_t;

  // How a segment ends once its switch edge is seen.
  typedef enum logic [1:0] {HHS_EK_STOP, HHS_EK_SLOW, HHS_EK_HOME} hhs_end_t;

  // What follows the end of a deceleration.
  typedef enum logic [1:0] {HHS_AF_SEG, HHS_AF_HOME, HHS_AF_ALARM} hhs_after_t;

  typedef enum logic [1:0] {HHS_S_IDLE, HHS_S_MOVE, HHS_S_DECEL} hhs_state_t;

  // One segment of travel: direction, speed, the switch edge that ends it.
  typedef struct packed {
    logic fwd;
    logic fast;
    logic rise;
    logic wait_pl;
    hhs_end_t end_kind;
  } hhs_seg_t;

  localparam hhs_seg_t HHS_SG_FH_PL = '{1'b1, 1'b1, 1'b0, 1'b1, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_RH_ON_STOP = '{1'b0, 1'b1, 1'b1, 1'b0, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_RH_ON_SLOW = '{1'b0, 1'b1, 1'b1, 1'b0, HHS_EK_SLOW};
  localparam hhs_seg_t HHS_SG_FH_ON_STOP = '{1'b1, 1'b1, 1'b1, 1'b0, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_FH_ON_SLOW = '{1'b1, 1'b1, 1'b1, 1'b0, HHS_EK_SLOW};
  localparam hhs_seg_t HHS_SG_FL_OFF_HOME = '{1'b1, 1'b0, 1'b0, 1'b0, HHS_EK_HOME};
  localparam hhs_seg_t HHS_SG_FL_OFF_STOP = '{1'b1, 1'b0, 1'b0, 1'b0, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_FL_ON_STOP = '{1'b1, 1'b0, 1'b1, 1'b0, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_FL_ON_HOME = '{1'b1, 1'b0, 1'b1, 1'b0, HHS_EK_HOME};
  localparam hhs_seg_t HHS_SG_RL_OFF_HOME = '{1'b0, 1'b0, 1'b0, 1'b0, HHS_EK_HOME};
  localparam hhs_seg_t HHS_SG_RL_OFF_STOP = '{1'b0, 1'b0, 1'b0, 1'b0, HHS_EK_STOP};
  localparam hhs_seg_t HHS_SG_RL_ON_HOME = '{1'b0, 1'b0, 1'b1, 1'b0, HHS_EK_HOME};
  localparam hhs_seg_t HHS_SG_RL_ON_STOP = '{1'b0, 1'b0, 1'b1, 1'b0, HHS_EK_STOP};

endpackage : hhs_pkg

// ---- hdl/hhs_sw_if.sv ----
// Interface carrying the synchronised switch levels and edges between the sequencer's modules.
interface hhs_sw_if;
  logic home;
  logic plim;
  logic nlim;
  logic home_rise;
  logic home_fall;
  logic plim_rise;

  modport src (output home, plim, nlim, home_rise, home_fall, plim_rise);
  modport dst (input home, plim, nlim, home_rise, home_fall, plim_rise);
endinterface : hhs_sw_if

// ---- hdl/hhs_sw_sync.sv ----
// Two-stage synchronisers for the home and limit switch pins, edge detection for home and positive limit.
module hhs_sw_sync
  import hhs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Raw switch pins.
  input wire logic [hhs_pkg::HHS_PIN_N-1:0] pins,
  // Synchronised levels and edges.
  hhs_sw_if.src sw
);

  logic [HHS_PIN_N-1:0] meta_r;
  logic [HHS_PIN_N-1:0] sync_r;
  logic [HHS_PIN_N-1:0] prev_r;

  // Edges compare the second stage with its delayed copy, never the first stage.
  for (genvar i = 0; i < HHS_PIN_N; i++) begin : g_pin
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
        prev_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pins[i];
        sync_r[i] <= meta_r[i];
        prev_r[i] <= sync_r[i];
      end
    end
  end

  assign sw.home = sync_r[HHS_PIN_HOME];
  assign sw.plim = sync_r[HHS_PIN_PLIM];
  assign sw.nlim = sync_r[HHS_PIN_NLIM];
  assign sw.home_rise = sync_r[HHS_PIN_HOME] & ~prev_r[HHS_PIN_HOME];
  assign sw.home_fall = ~sync_r[HHS_PIN_HOME] & prev_r[HHS_PIN_HOME];
  assign sw.plim_rise = sync_r[HHS_PIN_PLIM] & ~prev_r[HHS_PIN_PLIM];

endmodule : hhs_sw_sync

// ---- hdl/hhs_homing.sv ----
// Home-switch homing sequencer for search modes 21 to 26.
// Behaviour
// - Mode 21 off: reverse fast, forward slow, home.
// - Mode 21 on: forward slow, home on off.
// - Modes 21, 22: any limit aborts with alarm.
// - Mode 22 off: reverse fast, creep back, reverse.
// - Modes 22, 25 on: forward slow, reverse slow.
// - Modes 23-25 forward side: forward fast, limit reverses.
// - First positive limit forward reverses the direction.
// - Negative or second positive limit aborts with alarm.
// - Mode 23 turned: slow, back, reverse, home.
// - Overshoot past a narrow active region tolerated.
// - Mode 23 reverse side: forward fast, reverse slow.
// - Mode 23 on: reverse slow, home on off.
// - Mode 24 turned: slow, stop, forward slow.
// - Mode 24 reverse side: forward, creep back, forward.
// - Mode 24 on: reverse slow, forward slow.
// - Mode 25 turned: stop, creep back, reverse.
// - Mode 25 reverse side: fast, slow, reverse.
// - Mode 26: home on off, reverse at limit.
module hhs_homing
  import hhs_pkg::*;
#(
  parameter int POS_W = hhs_pkg::HHS_POS_W
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Switch pins, asynchronous to clk_sys.
  input wire logic home_switch,
  input wire logic positive_limit,
  input wire logic negative_limit,
  // Search control from the drive logic.
  input wire logic home_start,
  input wire hhs_pkg::hhs_mode_t home_mode,
  input wire logic start_fwd_side,
  input wire logic alarm_clear,
  // Motion feedback from the drive logic.
  input wire logic motor_stopped,
  input wire logic [POS_W-1:0] position,
  // Motion commands.
  output logic motor_run_r,
  output logic motor_fwd_r,
  output logic speed_high_r,
  output logic decel_stop_r,
  // Search status.
  output logic busy_r,
  output logic done_r,
  output logic alarm_r,
  output logic home_capture_r,
  output logic [POS_W-1:0] home_pos_r
);

  hhs_sw_if sw ();

  hhs_sw_sync u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pins({negative_limit, positive_limit, home_switch}),
    .sw(sw)
  );

  // Segment table: one entry per mode, start case and step.
  function automatic hhs_seg_t seg_lookup(hhs_mode_t m, hhs_case_t cs, logic [HHS_IDX_W-1:0] i);
    hhs_seg_t s;
    s = HHS_SG_RL_OFF_HOME;
    case (m)
      HHS_MODE_21: begin
        if (cs == HHS_CS_ON) begin
          s = HHS_SG_FL_OFF_HOME;
        end else begin
          s = (i == 3'h0) ? HHS_SG_RH_ON_STOP : HHS_SG_FL_OFF_HOME;
        end
      end
      HHS_MODE_22: begin
        if (cs == HHS_CS_ON) begin
          s = (i == 3'h0) ? HHS_SG_FL_OFF_STOP : HHS_SG_RL_ON_HOME;
        end else begin
          case (i)
            3'h0: s = HHS_SG_RH_ON_STOP;
            3'h1: s = HHS_SG_FL_OFF_STOP;
            default: s = HHS_SG_RL_ON_HOME;
          endcase
        end
      end
      HHS_MODE_23: begin
        case (cs)
          HHS_CS_ON: s = HHS_SG_RL_OFF_HOME;
          HHS_CS_OFF_REV: s = (i == 3'h0) ? HHS_SG_FH_ON_STOP : HHS_SG_RL_OFF_HOME;
          default: begin
            case (i)
              3'h0: s = HHS_SG_FH_PL;
              3'h1: s = HHS_SG_RH_ON_SLOW;
              3'h2: s = HHS_SG_RL_OFF_STOP;
              3'h3: s = HHS_SG_FL_ON_STOP;
              default: s = HHS_SG_RL_OFF_HOME;
            endcase
          end
        endcase
      end
      HHS_MODE_24: begin
        case (cs)
          HHS_CS_ON: s = (i == 3'h0) ? HHS_SG_RL_OFF_STOP : HHS_SG_FL_ON_HOME;
          HHS_CS_OFF_REV: begin
            case (i)
              3'h0: s = HHS_SG_FH_ON_STOP;
              3'h1: s = HHS_SG_RL_OFF_STOP;
              default: s = HHS_SG_FL_ON_HOME;
            endcase
          end
          default: begin
            case (i)
              3'h0: s = HHS_SG_FH_PL;
              3'h1: s = HHS_SG_RH_ON_SLOW;
              3'h2: s = HHS_SG_RL_OFF_STOP;
              default: s = HHS_SG_FL_ON_HOME;
            endcase
          end
        endcase
      end
      HHS_MODE_25: begin
        case (cs)
          HHS_CS_ON: s = (i == 3'h0) ? HHS_SG_FL_OFF_STOP : HHS_SG_RL_ON_HOME;
          HHS_CS_OFF_REV: begin
            case (i)
              3'h0: s = HHS_SG_FH_ON_SLOW;
              3'h1: s = HHS_SG_FL_OFF_STOP;
              default: s = HHS_SG_RL_ON_HOME;
            endcase
          end
          default: begin
            case (i)
              3'h0: s = HHS_SG_FH_PL;
              3'h1: s = HHS_SG_RH_ON_STOP;
              3'h2: s = HHS_SG_FL_OFF_STOP;
              default: s = HHS_SG_RL_ON_HOME;
            endcase
          end
        endcase
      end
      default: begin
        case (cs)
          HHS_CS_ON: s = HHS_SG_FL_OFF_HOME;
          HHS_CS_OFF_REV: begin
            case (i)
              3'h0: s = HHS_SG_FH_ON_SLOW;
              3'h1: s = HHS_SG_FL_OFF_STOP;
              3'h2: s = HHS_SG_RL_ON_STOP;
              default: s = HHS_SG_FL_OFF_HOME;
            endcase
          end
          default: begin
            case (i)
              3'h0: s = HHS_SG_FH_PL;
              3'h1: s = HHS_SG_RH_ON_STOP;
              default: s = HHS_SG_FL_OFF_HOME;
            endcase
          end
        endcase
      end
    endcase
    return s;
  endfunction : seg_lookup

  hhs_state_t st_r, st_nxt;
  hhs_after_t after_r, after_nxt;
  hhs_case_t cs_r, cs_nxt;
  hhs_mode_t mode_r, mode_nxt;
  logic [HHS_IDX_W-1:0] idx_r, idx_nxt;
  logic pl_seen_r, pl_seen_nxt;
  logic motor_run_nxt;
  logic motor_fwd_nxt;
  logic speed_high_nxt;
  logic decel_stop_nxt;
  logic done_nxt;
  logic alarm_nxt;
  logic home_capture_nxt;
  logic [POS_W-1:0] home_pos_nxt;

  // Decoding of the mode, the start case and the live events.
  wire hhs_seg_t seg = seg_lookup(mode_r, cs_r, idx_r);
  wire mode_in_lim = (home_mode == HHS_MODE_21) || (home_mode == HHS_MODE_22);
  wire mode_in_turn = (home_mode >= HHS_MODE_23) && (home_mode <= HHS_MODE_26);
  wire mode_in_ok = mode_in_lim || mode_in_turn;
  wire is_lim_mode = (mode_r == HHS_MODE_21) || (mode_r == HHS_MODE_22);
  wire is_turn_mode = !is_lim_mode;
  wire hhs_case_t start_case = sw.home ? HHS_CS_ON :
                               (start_fwd_side && mode_in_turn) ? HHS_CS_OFF_FWD :
                               HHS_CS_OFF_REV;
  wire start_ok = (st_r == HHS_S_IDLE) && home_start && mode_in_ok && !alarm_r;
  wire searching = (st_r != HHS_S_IDLE) && (after_r != HHS_AF_ALARM);
  // Narrow active region: an edge is only taken on a real transition, so an
  // overshoot across the switch simply shows up as a later edge of the wanted kind.
  wire seg_hit = !seg.wait_pl && (seg.rise ? sw.home_rise : sw.home_fall);
  wire lim_any = sw.plim || sw.nlim;
  wire pl_first = (st_r == HHS_S_MOVE) && is_turn_mode && seg.fwd && sw.plim && !pl_seen_r;
  wire pl_second = pl_seen_r && sw.plim_rise;
  wire abort_lim = searching && is_lim_mode && lim_any;
  wire abort_turn = searching && is_turn_mode && (sw.nlim || pl_second);
  wire abort_now = abort_lim || abort_turn;
  wire [HHS_IDX_W-1:0] idx_inc = idx_r + HHS_IDX_STEP;

  always_comb begin
    st_nxt = st_r;
    after_nxt = after_r;
    cs_nxt = cs_r;
    mode_nxt = mode_r;
    idx_nxt = idx_r;
    pl_seen_nxt = pl_seen_r;
    motor_run_nxt = motor_run_r;
    motor_fwd_nxt = motor_fwd_r;
    speed_high_nxt = speed_high_r;
    decel_stop_nxt = decel_stop_r;
    done_nxt = done_r;
    alarm_nxt = alarm_r;
    home_capture_nxt = 1'b0;
    home_pos_nxt = home_pos_r;
    case (st_r)
      HHS_S_IDLE: begin
        motor_run_nxt = 1'b0;
        speed_high_nxt = 1'b0;
        decel_stop_nxt = 1'b0;
        if (alarm_clear) begin
          alarm_nxt = 1'b0;
        end
        if (start_ok) begin
          mode_nxt = home_mode;
          cs_nxt = start_case;
          idx_nxt = HHS_IDX_FIRST;
          pl_seen_nxt = 1'b0;
          done_nxt = 1'b0;
          after_nxt = HHS_AF_SEG;
          st_nxt = HHS_S_MOVE;
        end
      end
      HHS_S_MOVE: begin
        motor_run_nxt = 1'b1;
        motor_fwd_nxt = seg.fwd;
        speed_high_nxt = seg.fast;
        decel_stop_nxt = 1'b0;
        if (abort_now) begin
          alarm_nxt = 1'b1;
          after_nxt = HHS_AF_ALARM;
          st_nxt = HHS_S_DECEL;
        end else if (pl_first) begin
          // Stop, then take up the forward-side sequence at its reverse fast leg.
          pl_seen_nxt = 1'b1;
          cs_nxt = HHS_CS_OFF_FWD;
          idx_nxt = HHS_IDX_AFTER_TURN;
          after_nxt = HHS_AF_SEG;
          st_nxt = HHS_S_DECEL;
        end else if (seg_hit) begin
          case (seg.end_kind)
            HHS_EK_SLOW: begin
              idx_nxt = idx_inc;
              speed_high_nxt = 1'b0;
            end
            HHS_EK_STOP: begin
              idx_nxt = idx_inc;
              after_nxt = HHS_AF_SEG;
              st_nxt = HHS_S_DECEL;
            end
            default: begin
              after_nxt = HHS_AF_HOME;
              st_nxt = HHS_S_DECEL;
            end
          endcase
        end
      end
      HHS_S_DECEL: begin
        motor_run_nxt = 1'b0;
        speed_high_nxt = 1'b0;
        decel_stop_nxt = 1'b1;
        if (abort_now) begin
          alarm_nxt = 1'b1;
          after_nxt = HHS_AF_ALARM;
        end
        // An abort that arrives at standstill still ends the search in this cycle.
        if (motor_stopped) begin
          decel_stop_nxt = 1'b0;
          case (after_nxt)
            HHS_AF_SEG: begin
              st_nxt = HHS_S_MOVE;
            end
            HHS_AF_HOME: begin
              home_pos_nxt = position;
              home_capture_nxt = 1'b1;
              done_nxt = 1'b1;
              st_nxt = HHS_S_IDLE;
            end
            default: begin
              st_nxt = HHS_S_IDLE;
            end
          endcase
        end
      end
      default: begin
        st_nxt = HHS_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= HHS_S_IDLE;
      after_r <= HHS_AF_SEG;
      cs_r <= HHS_CS_ON;
      mode_r <= HHS_MODE_21;
      idx_r <= HHS_IDX_FIRST;
      pl_seen_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      after_r <= after_nxt;
      cs_r <= cs_nxt;
      mode_r <= mode_nxt;
      idx_r <= idx_nxt;
      pl_seen_r <= pl_seen_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      motor_run_r <= HHS_RST_RUN;
      motor_fwd_r <= HHS_RST_FWD;
      speed_high_r <= HHS_RST_FAST;
      decel_stop_r <= HHS_RST_DECEL;
      busy_r <= 1'b0;
      done_r <= HHS_RST_DONE;
      alarm_r <= HHS_RST_ALARM;
      home_capture_r <= 1'b0;
      home_pos_r <= HHS_RST_POS[POS_W-1:0];
    end else begin
      motor_run_r <= motor_run_nxt;
      motor_fwd_r <= motor_fwd_nxt;
      speed_high_r <= speed_high_nxt;
      decel_stop_r <= decel_stop_nxt;
      busy_r <= (st_nxt != HHS_S_IDLE);
      done_r <= done_nxt;
      alarm_r <= alarm_nxt;
      home_capture_r <= home_capture_nxt;
      home_pos_r <= home_pos_nxt;
    end
  end

endmodule : hhs_homing

// ---- sim/hhs_homing_assertions.sv ----
// Checker with the concurrent properties of the homing sequencer's ports.
module hhs_homing_chk
  import hhs_pkg::*;
#(
  parameter int POS_W = hhs_pkg::HHS_POS_W
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Switch pins, search control and motion feedback.
  input wire logic home_switch,
  input wire logic positive_limit,
  input wire logic negative_limit,
  input wire logic home_start,
  input wire hhs_pkg::hhs_mode_t home_mode,
  input wire logic start_fwd_side,
  input wire logic alarm_clear,
  input wire logic motor_stopped,
  input wire logic [POS_W-1:0] position,
  // Commands and status.
  input wire logic motor_run_r,
  input wire logic motor_fwd_r,
  input wire logic speed_high_r,
  input wire logic decel_stop_r,
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic alarm_r,
  input wire logic home_capture_r,
  input wire logic [POS_W-1:0] home_pos_r
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire logic start_ok;
  wire logic no_limit;
  assign start_ok = home_start && !busy_r && !alarm_r && home_mode >= HHS_MODE_21
    && home_mode <= HHS_MODE_26;
  assign no_limit = !positive_limit && !negative_limit;

  start_taken_a: assert property (start_ok |=> busy_r && !done_r)
    else $error("accepted start did not raise busy");
  start_refused_a: assert property (home_start && !busy_r && !start_ok |=> !busy_r)
    else $error("refused start raised busy");
  mode21_first_a: assert property (start_ok && home_mode == HHS_MODE_21 && no_limit
    && $stable(home_switch) && home_switch == $past(home_switch, 2)
    |-> ##2 motor_run_r && motor_fwd_r == home_switch && speed_high_r == !home_switch)
    else $error("wrong first move in mode 21");
  fwd_fast_first_a: assert property (start_ok && home_mode >= HHS_MODE_23 && no_limit
    && !home_switch && !$past(home_switch) && !$past(home_switch, 2)
    |-> ##2 motor_run_r && motor_fwd_r && speed_high_r)
    else $error("search off the switch did not start forward fast");
  decel_stop_a: assert property (decel_stop_r |-> !motor_run_r && busy_r)
    else $error("run and stop commanded together");
  decel_release_a: assert property (decel_stop_r && motor_stopped |=> !decel_stop_r)
    else $error("stop command held after standstill");
  capture_value_a: assert property (home_capture_r |-> done_r && !busy_r
    && home_pos_r == $past(position))
    else $error("home position not latched from the stop position");
  capture_pulse_a: assert property (home_capture_r |=> !home_capture_r)
    else $error("capture pulse longer than one cycle");
  search_end_a: assert property ($fell(busy_r) |-> home_capture_r || alarm_r)
    else $error("search ended without home or alarm");
  limit_alarm_a: assert property (busy_r && negative_limit |-> ##[1:4] alarm_r)
    else $error("negative limit did not raise the alarm");
  alarm_hold_a: assert property (alarm_r && !(alarm_clear && !busy_r) |=> alarm_r)
    else $error("alarm dropped without a clear");
  alarm_clear_a: assert property (alarm_r && alarm_clear && !busy_r |=> !alarm_r)
    else $error("alarm clear ignored while idle");
endmodule : hhs_homing_chk

bind hhs_homing hhs_homing_chk #(.POS_W(POS_W)) i_hhs_homing_chk (
  .clk_sys, .resetn, .home_switch, .positive_limit, .negative_limit, .home_start,
  .home_mode, .start_fwd_side, .alarm_clear, .motor_stopped, .position, .motor_run_r,
  .motor_fwd_r, .speed_high_r, .decel_stop_r, .busy_r, .done_r, .alarm_r,
  .home_capture_r, .home_pos_r
);

// ---- sim/hhs_drive_model.sv ----
// Behavioural motor drive: integrates motion and derives the switch levels from position.
module hhs_drive_model #(
  parameter int PLIM_AT = 2000,
  parameter int NLIM_AT = -2000
) (
  // Clock, reset and commands.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic motor_run_r,
  input wire logic motor_fwd_r,
  input wire logic speed_high_r,
  input wire logic decel_stop_r,
  // Axis set-up from the bench.
  input wire logic pos_load,
  input wire logic signed [31:0] pos_init,
  input wire logic signed [31:0] home_lo,
  input wire logic signed [31:0] home_hi,
  input wire logic signed [31:0] stop_dly,
  // Switches and feedback.
  output logic home_switch,
  output logic positive_limit,
  output logic negative_limit,
  output logic motor_stopped,
  output logic [31:0] position
);
  timeunit 1ns;
  timeprecision 100ps;
  logic signed [31:0] pos_r;
  logic signed [31:0] coast_r;
  logic dir_r;
  wire logic signed [31:0] step;
  assign step = speed_high_r ? 32'sh2 : 32'sh1;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pos_r <= 32'sh0;
      coast_r <= 32'sh0;
      dir_r <= 1'b0;
    end else if (pos_load) begin
      pos_r <= pos_init;
      coast_r <= 32'sh0;
    end else if (motor_run_r) begin
      pos_r <= motor_fwd_r ? pos_r + step : pos_r - step;
      coast_r <= stop_dly;
      dir_r <= motor_fwd_r;
    end else if (decel_stop_r && coast_r > 0) begin
      // While the stop command stands the axis keeps creeping, so edges can be overshot.
      pos_r <= dir_r ? pos_r + 32'sh1 : pos_r - 32'sh1;
      coast_r <= coast_r - 32'sh1;
    end
  end
  assign home_switch = pos_r >= home_lo && pos_r <= home_hi;
  assign positive_limit = pos_r >= PLIM_AT;
  assign negative_limit = pos_r <= NLIM_AT;
  assign motor_stopped = !motor_run_r && coast_r == 0;
  assign position = pos_r;
endmodule : hhs_drive_model

// ---- sim/hhs_homing_tb.sv ----
// Self-checking testbench for the homing sequencer against a behavioural drive.
module hhs_homing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hhs_pkg::*;
  logic clk_sys;
  logic resetn;
  logic home_start;
  hhs_mode_t home_mode;
  logic start_fwd_side;
  logic alarm_clear;
  logic pos_load;
  logic signed [31:0] pos_init;
  logic signed [31:0] home_lo;
  logic signed [31:0] home_hi;
  logic signed [31:0] stop_dly;
  logic home_switch;
  logic positive_limit;
  logic negative_limit;
  logic motor_stopped;
  logic [31:0] position;
  logic motor_run_r;
  logic motor_fwd_r;
  logic speed_high_r;
  logic decel_stop_r;
  logic busy_r;
  logic done_r;
  logic alarm_r;
  logic home_capture_r;
  logic [31:0] home_pos_r;
  int fails;
  int checks;

  hhs_homing #(.POS_W(32)) i_hhs_homing (
    .clk_sys, .resetn, .home_switch, .positive_limit, .negative_limit, .home_start,
    .home_mode, .start_fwd_side, .alarm_clear, .motor_stopped, .position, .motor_run_r,
    .motor_fwd_r, .speed_high_r, .decel_stop_r, .busy_r, .done_r, .alarm_r,
    .home_capture_r, .home_pos_r
  );
  hhs_drive_model i_hhs_drive_model (
    .clk_sys, .resetn, .motor_run_r, .motor_fwd_r, .speed_high_r, .decel_stop_r, .pos_load,
    .pos_init, .home_lo, .home_hi, .stop_dly, .home_switch, .positive_limit, .negative_limit,
    .motor_stopped, .position
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict();
    $display("mismatches %0d of %0d comparisons", fails, checks);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic start_pulse(input hhs_mode_t m);
    home_mode = m;
    home_start = 1'b1;
    tick(1);
    home_start = 1'b0;
    tick(2);
  endtask : start_pulse

  // Places the axis, starts a search and judges the first move and the outcome.
  task automatic home_run(input hhs_mode_t m, input logic side, input int p0, input logic f0,
      input logic h0, input int lo, input int hi, input logic alm);
    int n;
    n = 0;
    pos_init = p0;
    pos_load = 1'b1;
    tick(1);
    pos_load = 1'b0;
    tick(4);
    start_fwd_side = side;
    start_pulse(m);
    chk(motor_run_r === 1'b1 && motor_fwd_r === f0 && speed_high_r === h0, "first move");
    while (busy_r !== 1'b0 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      $display("unexpected at %0t: search never ended", $time);
      give_verdict();
    end
    chk(alarm_r === alm && done_r === !alm, "end state");
    chk(home_capture_r === !alm && motor_run_r === 1'b0 && decel_stop_r === 1'b0, "release");
    if (!alm) chk($signed(home_pos_r) >= lo && $signed(home_pos_r) <= hi, "home position");
  endtask : home_run

  task automatic clear_alarm();
    alarm_clear = 1'b1;
    tick(1);
    alarm_clear = 1'b0;
    tick(1);
    chk(alarm_r === 1'b0, "alarm not cleared");
  endtask : clear_alarm

  task automatic s_mode21();
    home_run(HHS_MODE_21, 1'b0, 1500, 1'b0, 1'b1, 1041, 1060, 1'b0);
    stop_dly = 0;
    home_run(HHS_MODE_21, 1'b0, 1020, 1'b1, 1'b0, 1041, 1060, 1'b0);
    stop_dly = 3;
  endtask : s_mode21

  task automatic s_mode22();
    home_run(HHS_MODE_22, 1'b0, 1500, 1'b0, 1'b1, 1020, 1040, 1'b0);
    home_run(HHS_MODE_22, 1'b0, 1020, 1'b1, 1'b0, 1020, 1040, 1'b0);
  endtask : s_mode22

  task automatic s_mode23();
    home_run(HHS_MODE_23, 1'b1, 1500, 1'b1, 1'b1, 980, 999, 1'b0);
    home_run(HHS_MODE_23, 1'b0, 500, 1'b1, 1'b1, 980, 999, 1'b0);
    home_run(HHS_MODE_23, 1'b0, 1020, 1'b0, 1'b0, 980, 999, 1'b0);
  endtask : s_mode23

  task automatic s_mode24();
    home_run(HHS_MODE_24, 1'b1, 1500, 1'b1, 1'b1, 1000, 1020, 1'b0);
    home_run(HHS_MODE_24, 1'b0, 500, 1'b1, 1'b1, 1000, 1020, 1'b0);
    home_run(HHS_MODE_24, 1'b0, 1020, 1'b0, 1'b0, 1000, 1020, 1'b0);
  endtask : s_mode24

  task automatic s_mode25();
    home_run(HHS_MODE_25, 1'b1, 1500, 1'b1, 1'b1, 1020, 1040, 1'b0);
    home_run(HHS_MODE_25, 1'b0, 500, 1'b1, 1'b1, 1020, 1040, 1'b0);
    home_run(HHS_MODE_25, 1'b0, 1020, 1'b1, 1'b0, 1020, 1040, 1'b0);
    home_run(HHS_MODE_26, 1'b1, 1500, 1'b1, 1'b1, 1041, 1060, 1'b0);
  endtask : s_mode25

  // A narrow switch with a slow stopping drive makes the creep overshoot the far edge.
  task automatic s_narrow();
    home_hi = 1019;
    stop_dly = 20;
    home_run(HHS_MODE_23, 1'b1, 1500, 1'b1, 1'b1, 970, 999, 1'b0);
    home_hi = 1040;
    stop_dly = 3;
  endtask : s_narrow

  task automatic s_alarm();
    home_run(HHS_MODE_21, 1'b0, -1900, 1'b0, 1'b1, 0, 0, 1'b1);
    start_pulse(HHS_MODE_21);
    chk(busy_r === 1'b0 && alarm_r === 1'b1, "start taken under alarm");
    clear_alarm();
    home_run(HHS_MODE_22, 1'b0, -1900, 1'b0, 1'b1, 0, 0, 1'b1);
    clear_alarm();
    start_pulse(6'h14);
    chk(busy_r === 1'b0, "start taken for a foreign mode");
    home_lo = 5000;
    home_run(HHS_MODE_23, 1'b1, 1500, 1'b1, 1'b1, 0, 0, 1'b1);
    clear_alarm();
    home_lo = 1000;
  endtask : s_alarm

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    resetn = 1'b0;
    home_start = 1'b0;
    home_mode = HHS_MODE_21;
    start_fwd_side = 1'b0;
    alarm_clear = 1'b0;
    pos_load = 1'b0;
    pos_init = 32'sh0;
    home_lo = 1000;
    home_hi = 1040;
    stop_dly = 3;
    fails = 0;
    checks = 0;
    tick(10);
    resetn = 1'b1;
    tick(3);
    s_mode21();
    s_mode22();
    s_mode23();
    s_mode24();
    s_mode25();
    s_narrow();
    s_alarm();
    give_verdict();
  end
endmodule : hhs_homing_tb
